// ---- ptpcfg_pkg.sv ----
// Constants and register map of the time-protocol configuration register bank
// What this block does
// - Host writes a pin number; the interrupt then appears on that pin.
// - Pin select zero routes the interrupt to no pin at all.
// - Source select 00 internal, 01 divided internal, 1x external reference clock.
// - Nanoseconds adder adds the programmed period every reference clock cycle.
// - A written period below eight is stored as eight.
// - Divided source uses period bits 6 to 3 as divisor, ignores bits 2 to 0.
// - Layer2 messages are matched against the programmable type register.
// - Read-only offset field reports the byte offset to the message.
// - Monitor shows the twelve input levels, pin 12 to 1 on bits 11 to 0.
// - Hash enable turns on source identity filtering; clear means no filtering.
// - With filter on, an event message's receive timestamp is delivered only on hash match; other messages always are.
// - The filter never affects timestamp insertion into packets.
// - The expected hash is compared against each incoming event message's hash.
// - Reserved bits read zero and ignore writes.
package ptpcfg_pkg;

  localparam logic [4:0]  ADDR_INT_ROUTE    = 5'h1a;
  localparam logic [4:0]  ADDR_REF_SOURCE   = 5'h1b;
  localparam logic [4:0]  ADDR_TYPE_MATCH   = 5'h1c;
  localparam logic [4:0]  ADDR_MSG_OFFSET   = 5'h1d;
  localparam logic [4:0]  ADDR_PIN_MONITOR  = 5'h1e;
  localparam logic [4:0]  ADDR_ID_FILTER    = 5'h1f;

  localparam logic [15:0] TYPE_MATCH_RESET  = 16'hf788;
  localparam logic [3:0]  PIN_SELECT_RESET  = 4'h0;
  localparam logic [1:0]  SOURCE_SEL_RESET  = 2'h0;
  localparam logic [6:0]  PERIOD_RESET      = 7'h00;
  localparam logic [6:0]  PERIOD_MIN        = 7'h08;
  localparam logic [11:0] HASH_RESET        = 12'h000;

  localparam int PIN_SEL_LSB    = 0;
  localparam int SOURCE_SEL_LSB = 14;
  localparam int PERIOD_LSB     = 0;
  localparam int DIVISOR_LSB    = 3;
  localparam int HASH_EN_BIT    = 12;
  localparam int HASH_LSB       = 0;

  localparam logic [1:0]  SRC_INTERNAL = 2'h0;
  localparam logic [1:0]  SRC_DIVIDED  = 2'h1;

endpackage : ptpcfg_pkg

// ---- ptpcfg_bank.sv ----
// Configuration register bank and its direct steering logic for the time-protocol unit
`timescale 1ns/1ps
module ptpcfg_bank #(
  parameter int NUM_PINS = 12,
  parameter int NS_WIDTH = 32
) (
  input  wire logic                core_clk,
  input  wire logic                rst_b,
  input  wire logic                reg_wr_en,
  input  wire logic [4:0]          reg_addr,
  input  wire logic [15:0]         reg_wdata,
  output logic      [15:0]         reg_rdata,
  input  wire logic                ptp_int_event,
  output logic      [NUM_PINS-1:0] int_pin_out,
  input  wire logic [NUM_PINS-1:0] pin_input_levels,
  input  wire logic                ext_ref_tick,
  output logic                     ref_tick,
  output logic      [NS_WIDTH-1:0] ns_count,
  input  wire logic                rx_frame_type_valid,
  input  wire logic [15:0]         rx_frame_type,
  output logic                     layer2_match,
  input  wire logic [7:0]          parser_offset_bytes,
  input  wire logic                rx_ts_valid,
  input  wire logic                rx_event_msg,
  input  wire logic [11:0]         rx_identity_hash,
  output logic                     rx_ts_deliver,
  input  wire logic                tx_insert_in,
  output logic                     tx_insert_out
);

  ////////////////////////////////////////////////////////////////////////////
  logic [3:0]           interrupt_pin_select_reg;
  logic [1:0]           reference_source_select_reg;
  logic [6:0]           reference_period_ns_reg;
  logic [15:0]          layer2_type_value_reg;
  logic [7:0]           message_offset_bytes_reg;
  logic [NUM_PINS-1:0]  pin_input_levels_reg;
  logic                 hash_enable_reg;
  logic [11:0]          expected_identity_hash_reg;
  // Divider state for the divided internal source
  logic [3:0]           div_count_reg;
  logic [3:0]           divisor;
  logic                 div_tick;

  // Address compare shared by every writable register
  function automatic logic wr_hit(input logic [4:0] a, input logic [4:0] target);
    wr_hit = (a == target);
  endfunction : wr_hit

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; reserved bits are never stored
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      interrupt_pin_select_reg <= ptpcfg_pkg::PIN_SELECT_RESET;
    end
    else if (reg_wr_en && wr_hit(reg_addr, ptpcfg_pkg::ADDR_INT_ROUTE))
    begin
      interrupt_pin_select_reg <= reg_wdata[ptpcfg_pkg::PIN_SEL_LSB +: 4];
    end
  end

  // A new source takes effect at once; the divider phase is not restarted
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reference_source_select_reg <= ptpcfg_pkg::SOURCE_SEL_RESET;
    end
    else if (reg_wr_en && wr_hit(reg_addr, ptpcfg_pkg::ADDR_REF_SOURCE))
    begin
      reference_source_select_reg <= reg_wdata[ptpcfg_pkg::SOURCE_SEL_LSB +: 2];
    end
  end

  // Clamp keeps a written period from going below the smallest legal period; reset still loads zero
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reference_period_ns_reg <= ptpcfg_pkg::PERIOD_RESET;
    end
    else if (reg_wr_en && wr_hit(reg_addr, ptpcfg_pkg::ADDR_REF_SOURCE))
    begin
      if (reg_wdata[ptpcfg_pkg::PERIOD_LSB +: 7] < ptpcfg_pkg::PERIOD_MIN)
      begin
        reference_period_ns_reg <= ptpcfg_pkg::PERIOD_MIN;
      end
      else
      begin
        reference_period_ns_reg <= reg_wdata[ptpcfg_pkg::PERIOD_LSB +: 7];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      layer2_type_value_reg <= ptpcfg_pkg::TYPE_MATCH_RESET;
    end
    else if (reg_wr_en && wr_hit(reg_addr, ptpcfg_pkg::ADDR_TYPE_MATCH))
    begin
      layer2_type_value_reg <= reg_wdata;
    end
  end

  // Enable and expected value share one write, so the filter never sees half a setting
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hash_enable_reg <= 1'b0;
    end
    else if (reg_wr_en && wr_hit(reg_addr, ptpcfg_pkg::ADDR_ID_FILTER))
    begin
      hash_enable_reg <= reg_wdata[ptpcfg_pkg::HASH_EN_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      expected_identity_hash_reg <= ptpcfg_pkg::HASH_RESET;
    end
    else if (reg_wr_en && wr_hit(reg_addr, ptpcfg_pkg::ADDR_ID_FILTER))
    begin
      expected_identity_hash_reg <= reg_wdata[ptpcfg_pkg::HASH_LSB +: 12];
    end
  end

  // Offset is resampled every cycle; the parser holds it steady between frames
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      message_offset_bytes_reg <= 8'h00;
    end
    else
    begin
      message_offset_bytes_reg <= parser_offset_bytes;
    end
  end

  // Pins are taken as synchronous, so one flop suffices; the monitor lags one cycle
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_input_levels_reg <= '0;
    end
    else
    begin
      pin_input_levels_reg <= pin_input_levels;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses and reserved bits read zero
  always_comb
  begin
    reg_rdata = 16'h0000;
    unique case (reg_addr)
      ptpcfg_pkg::ADDR_INT_ROUTE:   reg_rdata[3:0] = interrupt_pin_select_reg;
      ptpcfg_pkg::ADDR_REF_SOURCE:
      begin
        reg_rdata[15:14] = reference_source_select_reg;
        reg_rdata[6:0]   = reference_period_ns_reg;
      end
      ptpcfg_pkg::ADDR_TYPE_MATCH:  reg_rdata = layer2_type_value_reg;
      ptpcfg_pkg::ADDR_MSG_OFFSET:  reg_rdata[7:0] = message_offset_bytes_reg;
      ptpcfg_pkg::ADDR_PIN_MONITOR: reg_rdata[NUM_PINS-1:0] = pin_input_levels_reg;
      ptpcfg_pkg::ADDR_ID_FILTER:
      begin
        reg_rdata[12]   = hash_enable_reg;
        reg_rdata[11:0] = expected_identity_hash_reg;
      end
      default:                      reg_rdata = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt routing: pin number n drives bit n-1; zero drives nothing
  // Codes above the pin count route nowhere
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++)
    begin : g_int_route
      always_ff @(posedge core_clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          int_pin_out[g] <= 1'b0;
        end
        else
        begin
          int_pin_out[g] <= ptp_int_event &&
                            (interrupt_pin_select_reg == 4'(g + 1));
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Reference tick: divider on core_clk for the divided source
  // Low period bits are ignored while dividing
  assign divisor = reference_period_ns_reg[ptpcfg_pkg::DIVISOR_LSB +: 4];

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_count_reg <= 4'h0;
    end
    else if (div_tick)
    begin
      div_count_reg <= 4'h0;
    end
    else
    begin
      div_count_reg <= div_count_reg + 4'h1;
    end
  end

  // Divisor of 0 or 1 degrades to every cycle rather than stalling time
  assign div_tick = (div_count_reg + 4'h1 >= divisor);

  // External ticks are taken as already synchronous to core_clk
  always_comb
  begin
    if (reference_source_select_reg == ptpcfg_pkg::SRC_INTERNAL)
    begin
      ref_tick = 1'b1;
    end
    else if (reference_source_select_reg == ptpcfg_pkg::SRC_DIVIDED)
    begin
      ref_tick = div_tick;
    end
    else
    begin
      ref_tick = ext_ref_tick;
    end
  end

  // Time wraps silently at the counter width
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ns_count <= '0;
    end
    else if (ref_tick)
    begin
      ns_count <= ns_count + NS_WIDTH'(reference_period_ns_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive-side filters
  // Type compare is registered to keep the parser path short
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      layer2_match <= 1'b0;
    end
    else
    begin
      layer2_match <= rx_frame_type_valid && (rx_frame_type == layer2_type_value_reg);
    end
  end

  // Hash input is produced by a fixed function upstream of this bank
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_ts_deliver <= 1'b0;
    end
    else
    begin
      rx_ts_deliver <= rx_ts_valid && (!hash_enable_reg || !rx_event_msg ||
                       (rx_identity_hash == expected_identity_hash_reg));
    end
  end

  // One flop keeps insertion aligned with the delivery strobe
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tx_insert_out <= 1'b0;
    end
    else
    begin
      tx_insert_out <= tx_insert_in;
    end
  end

endmodule : ptpcfg_bank

// ---- ptpcfg_bank_asserts.sv ----
// Port-level checker of the time-protocol register bank
`timescale 1ns/1ps
module ptpcfg_bank_asserts #(
  parameter int NUM_PINS = 12,
  parameter int NS_WIDTH = 32
) (
  input wire logic                core_clk,
  input wire logic                rst_b,
  input wire logic                reg_wr_en,
  input wire logic [4:0]          reg_addr,
  input wire logic [15:0]         reg_wdata,
  input wire logic [15:0]         reg_rdata,
  input wire logic                ptp_int_event,
  input wire logic [NUM_PINS-1:0] int_pin_out,
  input wire logic                ext_ref_tick,
  input wire logic                ref_tick,
  input wire logic [NS_WIDTH-1:0] ns_count,
  input wire logic                rx_frame_type_valid,
  input wire logic [15:0]         rx_frame_type,
  input wire logic                layer2_match,
  input wire logic                rx_ts_valid,
  input wire logic                rx_event_msg,
  input wire logic [11:0]         rx_identity_hash,
  input wire logic                rx_ts_deliver,
  input wire logic                tx_insert_in,
  input wire logic                tx_insert_out
);
  logic [3:0]          sel_q;
  logic [1:0]          src_q;
  logic [6:0]          per_q;
  logic [15:0]         type_q;
  logic [12:0]         flt_q;
  logic [NUM_PINS-1:0] pin_exp;
  logic                wr_src;
  assign wr_src = reg_wr_en && reg_addr == ptpcfg_pkg::ADDR_REF_SOURCE;
  assign pin_exp = (sel_q == 4'h0) ? '0 : NUM_PINS'(1) << (sel_q - 4'h1);
  // Shadow of the host-written settings, kept apart from the design's own state
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
    begin
      sel_q  <= 4'h0;
      src_q  <= 2'h0;
      per_q  <= 7'h00;
      type_q <= ptpcfg_pkg::TYPE_MATCH_RESET;
      flt_q  <= 13'h0000;
    end
    else if (reg_wr_en)
    begin
      if (reg_addr == ptpcfg_pkg::ADDR_INT_ROUTE) sel_q <= reg_wdata[3:0];
      if (wr_src) src_q <= reg_wdata[15:14];
      if (wr_src) per_q <= (reg_wdata[6:0] < 7'h08) ? 7'h08 : reg_wdata[6:0];
      if (reg_addr == ptpcfg_pkg::ADDR_TYPE_MATCH) type_q <= reg_wdata;
      if (reg_addr == ptpcfg_pkg::ADDR_ID_FILTER) flt_q <= reg_wdata[12:0];
    end
  ////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_short_write;
    wr_src && reg_wdata[6:0] < 7'h08;
  endsequence
  property p_int_route;
    ptp_int_event && sel_q != 4'h0 |=> int_pin_out == $past(pin_exp);
  endproperty
  a_int_route: assert property (p_int_route) else $error("pin route wrong");
  property p_int_off;
    sel_q == 4'h0 |=> int_pin_out == '0;
  endproperty
  a_int_off: assert property (p_int_off) else $error("pin driven while off");
  property p_source;
    src_q != ptpcfg_pkg::SRC_DIVIDED |-> ref_tick == (src_q[1] ? ext_ref_tick : 1'b1);
  endproperty
  a_source: assert property (p_source) else $error("tick source wrong");
  property p_adder;
    1 |=> ns_count == $past(ns_count) + ($past(ref_tick) ? NS_WIDTH'($past(per_q)) : '0);
  endproperty
  a_adder: assert property (p_adder) else $error("ns step wrong");
  property p_min_period;
    s_short_write |=> reg_addr != ptpcfg_pkg::ADDR_REF_SOURCE || reg_rdata[6:0] == 7'h08;
  endproperty
  a_min_period: assert property (p_min_period) else $error("period not clamped");
  property p_type;
    1 |=> layer2_match == $past(rx_frame_type_valid && rx_frame_type == type_q);
  endproperty
  a_type: assert property (p_type) else $error("type match wrong");
  property p_filter;
    1 |=> rx_ts_deliver == $past(rx_ts_valid &&
      (!(rx_event_msg && flt_q[12]) || rx_identity_hash == flt_q[11:0]));
  endproperty
  a_filter: assert property (p_filter) else $error("delivery wrong");
  property p_insert;
    1 |=> tx_insert_out == $past(tx_insert_in);
  endproperty
  a_insert: assert property (p_insert) else $error("insert strobe wrong");
  property p_reserved;
    (reg_addr != 5'h1a || reg_rdata[15:4] == 12'h000) &&
      (reg_addr != 5'h1b || reg_rdata[13:7] == 7'h00);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");
endmodule : ptpcfg_bank_asserts
bind ptpcfg_bank ptpcfg_bank_asserts #(.NUM_PINS(NUM_PINS), .NS_WIDTH(NS_WIDTH)) chk_u (.*);

// ---- ptpcfg_host_model.sv ----
// Management host model issuing register writes and reads
`timescale 1ns/1ps
module ptpcfg_host_model (
  input  wire logic        core_clk,
  output logic             reg_wr_en,
  output logic [4:0]       reg_addr,
  output logic [15:0]      reg_wdata,
  input  wire logic [15:0] reg_rdata
);
  initial
  begin
    reg_wr_en = 1'b0;
    reg_addr  = 5'h00;
    reg_wdata = 16'h0000;
  end
  // Data is scrambled after the strobe so a stale value can never pass
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr_en <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr_en <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    @(negedge core_clk);
    d = reg_rdata;
  endtask : rd
endmodule : ptpcfg_host_model

// ---- tb_top.sv ----
// Self-checking testbench of the time-protocol register bank
`timescale 1ns/1ps
module tb_top;
  logic core_clk, rst_b, reg_wr_en, ptp_int_event, ext_ref_tick, ref_tick, layer2_match;
  logic rx_frame_type_valid, rx_ts_valid, rx_event_msg, rx_ts_deliver, tx_insert_in, tx_insert_out;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rx_frame_type, rd_v;
  logic [11:0] int_pin_out, pin_input_levels, rx_identity_hash;
  logic [7:0]  parser_offset_bytes;
  logic [31:0] ns_count, base;
  int          fails, compares, n, cnt;
  localparam logic [4:0]  ADR [7] = '{5'h00, 5'h1a, 5'h1b, 5'h1c, 5'h1d, 5'h1e, 5'h1f};
  localparam logic [15:0] RST [7] = '{16'h0000, 16'h0000, 16'h0000, 16'hf788,
                                      16'h0000, 16'h0000, 16'h0000};
  localparam logic [15:0] FUL [7] = '{0, 16'h000f, 16'hc07f, 16'hffff, 16'h005a, 16'h0a53, 16'h1fff};
  localparam logic [15:0] TCF [5] = '{16'h0010, 16'h4050, 16'h8010, 16'h4007, 16'hc010};
  localparam logic [15:0] TCN [5] = '{16'h0028, 16'h0004, 16'h0014, 16'h0028, 16'h0014};
  localparam logic [15:0] TNS [5] = '{16'h0280, 16'h0140, 16'h0140, 16'h0140, 16'h0140};
  ptpcfg_bank dut_u (.*);
  ptpcfg_host_model host_u (.*);
  ////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic st(input logic [15:0] t, input logic ev, input logic [11:0] h, input logic [2:0] e);
    @(posedge core_clk);
    {rx_frame_type_valid, rx_ts_valid, tx_insert_in} <= 3'h7;
    {rx_frame_type, rx_event_msg, rx_identity_hash} <= {t, ev, h};
    @(posedge core_clk);
    {rx_frame_type_valid, rx_ts_valid, tx_insert_in} <= 3'h0;
    @(negedge core_clk);
    chk({13'h0, layer2_match, rx_ts_deliver, tx_insert_out}, {13'h0, e});
  endtask : st
  task automatic end_of_test;
    $display("Compares %0d, fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) ext_ref_tick <= (ext_ref_tick !== 1'b1);
  initial
  begin
    #100000;
    fails++;
    end_of_test;
  end
  initial
  begin
    {rst_b, ptp_int_event, rx_frame_type_valid, rx_ts_valid} = '0;
    {rx_event_msg, tx_insert_in, rx_frame_type, rx_identity_hash} = '0;
    {pin_input_levels, parser_offset_bytes} = '0;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    for (n = 0; n < 7; n++)
    begin
      host_u.rd(ADR[n], rd_v);
      chk(rd_v, RST[n]);
    end
    @(posedge core_clk);
    pin_input_levels    <= 12'ha53;
    parser_offset_bytes <= 8'h5a;
    for (n = 0; n < 7; n++) host_u.wr(ADR[n], 16'hffff);
    for (n = 0; n < 7; n++)
    begin
      host_u.rd(ADR[n], rd_v);
      chk(rd_v, FUL[n]);
    end
    host_u.wr(5'h1b, 16'h4003);
    host_u.rd(5'h1b, rd_v);
    chk(rd_v, 16'h4008);
    // Windows are whole multiples of every period, so tick phase does not matter
    for (n = 0; n < 5; n++)
    begin
      host_u.wr(5'h1b, TCF[n]);
      @(negedge core_clk);
      base = ns_count;
      cnt  = int'(ref_tick);
      repeat (39) @(negedge core_clk) cnt += int'(ref_tick);
      @(negedge core_clk);
      chk(16'(cnt), TCN[n]);
      chk(16'(ns_count - base), TNS[n]);
    end
    @(posedge core_clk);
    ptp_int_event <= 1'b1;
    // The route feeds a flop, so the pin follows one edge after the write lands
    for (n = 0; n < 13; n++)
    begin
      host_u.wr(5'h1a, 16'(n));
      repeat (2) @(negedge core_clk);
      chk({4'h0, int_pin_out}, (n > 0) ? 16'h1 << (n - 1) : 16'h0);
    end
    @(posedge core_clk);
    ptp_int_event <= 1'b0;
    repeat (2) @(negedge core_clk);
    chk({4'h0, int_pin_out}, 16'h0000);
    host_u.wr(5'h1c, 16'h88f7);
    host_u.wr(5'h1f, 16'h1abc);
    st(16'h88f7, 1'b1, 12'habc, 3'h7);
    st(16'hf788, 1'b1, 12'habd, 3'h1);
    st(16'h88f7, 1'b0, 12'habd, 3'h7);
    host_u.wr(5'h1f, 16'h0abc);
    st(16'hf788, 1'b1, 12'habd, 3'h3);
    end_of_test;
  end
endmodule : tb_top
